// [hdl/sdi_pkg.sv]
// shared constants and types of the step/direction microstep indexer
package sdi_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int POS_W = 10;
    localparam int MAG_W = 8;
    localparam int RES_W = 4;
    localparam int TAB_AW = 8;
    localparam int IRQ_W = 2;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_POSITION = 8'h04;
    localparam logic [7:0] OFS_CURRENT = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h14;

    // field positions
    localparam int CTRL_DUAL_EDGE_SELECT_BIT = 0;
    localparam int CTRL_RES_LSB = 4;
    localparam int CUR_A_MAG_LSB = 0;
    localparam int CUR_A_POL_BIT = 8;
    localparam int CUR_B_MAG_LSB = 16;
    localparam int CUR_B_POL_BIT = 24;
    localparam int STAT_STANDSTILL_BIT = 0;
    localparam int STAT_DIR_BIT = 1;
    localparam int STAT_STEP_BIT = 2;
    localparam int IRQ_STANDSTILL_BIT = 0;
    localparam int IRQ_RESUME_BIT = 1;

    // reset values
    localparam logic RST_DUAL_EDGE_SELECT = 1'h0;
    localparam logic [RES_W-1:0] RST_RES = 4'h0;
    localparam logic [POS_W-1:0] RST_POSITION = 10'h000;
    localparam logic [IRQ_W-1:0] RST_IRQ_MASK = 2'h0;

    // coarsest resolution code: one full step per edge
    localparam logic [RES_W-1:0] RES_FULL = 4'h8;
    // quarter wave offset between the coils
    localparam logic [POS_W-1:0] QUARTER_WAVE = 10'h100;

    // idle cycles before standstill is reported
    localparam int STANDSTILL_CYCLES = 2 ** 20;

    typedef struct packed {
        logic dual_edge_select;
        logic [RES_W-1:0] resolution_select;
    } sdi_ctrl_s;

    typedef struct packed {
        logic polarity;
        logic [MAG_W-1:0] magnitude;
    } sdi_coil_s;

endpackage

// [hdl/sdi_sync.sv]
// two flip-flop synchroniser for asynchronous pin inputs
`timescale 1ns/10ps
module sdi_sync #(
    parameter int WIDTH = 2
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    // first stage feeds only the second stage
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            meta_ff <= '0;
            sync_ff <= '0;
        end
        else
        begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;

endmodule

// [hdl/sdi_sine_rom.sv]
// quarter-wave sine table with two registered read ports
`timescale 1ns/10ps
module sdi_sine_rom #(
    parameter int AW = 8,
    parameter int DW = 8
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [AW-1:0] addr_a,
    input wire logic [AW-1:0] addr_b,
    output logic [DW-1:0] data_a,
    output logic [DW-1:0] data_b
);

    // first quarter of the sine, 1 rising to a peak of 248
    localparam logic [DW-1:0] TABLE [2**AW] = '{
        8'h01, 8'h02, 8'h04, 8'h05, 8'h07, 8'h08, 8'h0A, 8'h0B, 8'h0D, 8'h0E, 8'h10, 8'h11, 8'h13, 8'h15, 8'h16, 8'h18,
        8'h19, 8'h1B, 8'h1C, 8'h1E, 8'h1F, 8'h21, 8'h22, 8'h24, 8'h25, 8'h27, 8'h28, 8'h2A, 8'h2B, 8'h2D, 8'h2E, 8'h30,
        8'h31, 8'h33, 8'h34, 8'h36, 8'h37, 8'h39, 8'h3A, 8'h3C, 8'h3D, 8'h3E, 8'h40, 8'h41, 8'h43, 8'h44, 8'h46, 8'h47,
        8'h49, 8'h4A, 8'h4C, 8'h4D, 8'h4F, 8'h50, 8'h51, 8'h53, 8'h54, 8'h56, 8'h57, 8'h59, 8'h5A, 8'h5B, 8'h5D, 8'h5E,
        8'h60, 8'h61, 8'h62, 8'h64, 8'h65, 8'h67, 8'h68, 8'h69, 8'h6B, 8'h6C, 8'h6D, 8'h6F, 8'h70, 8'h72, 8'h73, 8'h74,
        8'h76, 8'h77, 8'h78, 8'h7A, 8'h7B, 8'h7C, 8'h7E, 8'h7F, 8'h80, 8'h81, 8'h83, 8'h84, 8'h85, 8'h87, 8'h88, 8'h89,
        8'h8A, 8'h8C, 8'h8D, 8'h8E, 8'h8F, 8'h91, 8'h92, 8'h93, 8'h94, 8'h96, 8'h97, 8'h98, 8'h99, 8'h9A, 8'h9C, 8'h9D,
        8'h9E, 8'h9F, 8'hA0, 8'hA1, 8'hA3, 8'hA4, 8'hA5, 8'hA6, 8'hA7, 8'hA8, 8'hA9, 8'hAA, 8'hAC, 8'hAD, 8'hAE, 8'hAF,
        8'hB0, 8'hB1, 8'hB2, 8'hB3, 8'hB4, 8'hB5, 8'hB6, 8'hB7, 8'hB8, 8'hB9, 8'hBA, 8'hBB, 8'hBC, 8'hBD, 8'hBE, 8'hBF,
        8'hC0, 8'hC1, 8'hC2, 8'hC3, 8'hC4, 8'hC5, 8'hC6, 8'hC7, 8'hC8, 8'hC9, 8'hC9, 8'hCA, 8'hCB, 8'hCC, 8'hCD, 8'hCE,
        8'hCF, 8'hCF, 8'hD0, 8'hD1, 8'hD2, 8'hD3, 8'hD4, 8'hD4, 8'hD5, 8'hD6, 8'hD7, 8'hD7, 8'hD8, 8'hD9, 8'hDA, 8'hDA,
        8'hDB, 8'hDC, 8'hDC, 8'hDD, 8'hDE, 8'hDF, 8'hDF, 8'hE0, 8'hE1, 8'hE1, 8'hE2, 8'hE2, 8'hE3, 8'hE4, 8'hE4, 8'hE5,
        8'hE5, 8'hE6, 8'hE7, 8'hE7, 8'hE8, 8'hE8, 8'hE9, 8'hE9, 8'hEA, 8'hEA, 8'hEB, 8'hEB, 8'hEC, 8'hEC, 8'hED, 8'hED,
        8'hEE, 8'hEE, 8'hEE, 8'hEF, 8'hEF, 8'hF0, 8'hF0, 8'hF0, 8'hF1, 8'hF1, 8'hF1, 8'hF2, 8'hF2, 8'hF2, 8'hF3, 8'hF3,
        8'hF3, 8'hF4, 8'hF4, 8'hF4, 8'hF4, 8'hF5, 8'hF5, 8'hF5, 8'hF5, 8'hF6, 8'hF6, 8'hF6, 8'hF6, 8'hF6, 8'hF7, 8'hF7,
        8'hF7, 8'hF7, 8'hF7, 8'hF7, 8'hF7, 8'hF7, 8'hF8, 8'hF8, 8'hF8, 8'hF8, 8'hF8, 8'hF8, 8'hF8, 8'hF8, 8'hF8, 8'hF8
    };

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            data_a <= '0;
            data_b <= '0;
        end
        else
        begin
            data_a <= TABLE[addr_a];
            data_b <= TABLE[addr_b];
        end
    end

endmodule

// [hdl/sdi_indexer.sv]
// step/direction front end and microstep indexer with register port
//
// How it works
// - dual edge select set: both step edges count; clear: rising only
// - step and direction pass a two flip-flop synchroniser before edge detection
// - electrical angle is an unsigned 10-bit microstep position counter
// - resolution select sets the step size added per active edge
// - direction low adds the step size, direction high subtracts it
// - quarter wave table, quadrant symmetry yields full circle sine and cosine
// - table peak is 248, below full scale
// - 256 table entries rising from 1 to 248
// - position top bit sets coil A polarity, zero first to second
// - standstill flag set after 2^20 cycles without an active edge
//
// Added by the designer: the register addresses and the plain strobed port.
`timescale 1ns/10ps
module sdi_indexer
    import sdi_pkg::*;
#(
    parameter int STANDSTILL_LIMIT = sdi_pkg::STANDSTILL_CYCLES
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic step_pin,
    input wire logic dir_pin,
    input wire logic [sdi_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [sdi_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [sdi_pkg::DATA_W-1:0] reg_rdata,
    output logic irq,
    output logic [sdi_pkg::POS_W-1:0] microstep_position,
    output sdi_pkg::sdi_coil_s coil_a,
    output sdi_pkg::sdi_coil_s coil_b,
    output logic coil_a_out_first,
    output logic coil_a_out_second,
    output logic coil_b_out_first,
    output logic coil_b_out_second,
    output logic standstill_flag
);

    import sdi_pkg::*;

    localparam int CNT_W = $clog2(STANDSTILL_LIMIT + 1);

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // step size is a power of two; codes above full step clamp to it
    function automatic logic [POS_W-1:0] step_size(input logic [RES_W-1:0] res);
        logic [RES_W-1:0] lim;
        lim = (res > RES_FULL) ? RES_FULL : res;
        step_size = POS_W'(1) << lim;
    endfunction

    // odd quadrants read the table backwards
    function automatic logic [TAB_AW-1:0] mirror_index(input logic [POS_W-1:0] pos);
        mirror_index = pos[TAB_AW] ? ~pos[TAB_AW-1:0] : pos[TAB_AW-1:0];
    endfunction

    function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [7:0] ofs);
        reg_hit = (addr == ofs);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisation and edge detection

    logic [1:0] pins_sync;
    logic step_sync;
    logic dir_sync;
    logic step_prev_ff;
    logic active_edge;
    sdi_ctrl_s ctrl_ff;

    sdi_sync #(
        .WIDTH(2)
    ) u_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .async_in({dir_pin, step_pin}),
        .sync_out(pins_sync)
    );

    assign step_sync = pins_sync[0];
    assign dir_sync = pins_sync[1];

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            step_prev_ff <= 1'b0;
        end
        else
        begin
            step_prev_ff <= step_sync;
        end
    end

    // one edge per clock at most, hence the external step rate ceiling
    always_comb
    begin
        if (ctrl_ff.dual_edge_select)
        begin
            active_edge = step_sync ^ step_prev_ff;
        end
        else
        begin
            active_edge = step_sync & ~step_prev_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // microstep counter

    logic [POS_W-1:0] position_ff;
    logic [POS_W-1:0] nxt_position;

    // natural 10-bit overflow gives the modulo 1024 wrap both ways
    always_comb
    begin
        nxt_position = position_ff;
        if (active_edge)
        begin
            if (dir_sync)
            begin
                nxt_position = position_ff - step_size(ctrl_ff.resolution_select);
            end
            else
            begin
                nxt_position = position_ff + step_size(ctrl_ff.resolution_select);
            end
        end
    end

    // no realignment on a resolution change; coarse grids rely on the controller
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            position_ff <= RST_POSITION;
        end
        else
        begin
            position_ff <= nxt_position;
        end
    end

    assign microstep_position = position_ff;

    ////////////////////////////////////////////////////////////////////////////
    // sine and cosine lookup

    logic [POS_W-1:0] pos_b;
    logic [MAG_W-1:0] mag_a;
    logic [MAG_W-1:0] mag_b;
    logic pol_a_ff;
    logic pol_b_ff;

    // cosine is the sine a quarter wave ahead
    assign pos_b = position_ff + QUARTER_WAVE;

    sdi_sine_rom #(
        .AW(TAB_AW),
        .DW(MAG_W)
    ) u_rom (
        .clk(clk),
        .sys_rst(sys_rst),
        .addr_a(mirror_index(position_ff)),
        .addr_b(mirror_index(pos_b)),
        .data_a(mag_a),
        .data_b(mag_b)
    );

    // polarity delayed to line up with the registered table read
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pol_a_ff <= 1'b0;
            pol_b_ff <= 1'b0;
        end
        else
        begin
            pol_a_ff <= position_ff[POS_W-1];
            pol_b_ff <= pos_b[POS_W-1];
        end
    end

    assign coil_a = '{polarity: pol_a_ff, magnitude: mag_a};
    assign coil_b = '{polarity: pol_b_ff, magnitude: mag_b};
    assign coil_a_out_first = ~pol_a_ff;
    assign coil_a_out_second = pol_a_ff;
    assign coil_b_out_first = ~pol_b_ff;
    assign coil_b_out_second = pol_b_ff;

    ////////////////////////////////////////////////////////////////////////////
    // standstill detection

    logic [CNT_W-1:0] idle_cnt_ff;
    logic standstill_ff;

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            idle_cnt_ff <= '0;
        end
        else if (active_edge)
        begin
            idle_cnt_ff <= '0;
        end
        else if (idle_cnt_ff != CNT_W'(STANDSTILL_LIMIT))
        begin
            idle_cnt_ff <= idle_cnt_ff + CNT_W'(1);
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            standstill_ff <= 1'b0;
        end
        else if (active_edge)
        begin
            standstill_ff <= 1'b0;
        end
        else if (idle_cnt_ff == CNT_W'(STANDSTILL_LIMIT - 1))
        begin
            standstill_ff <= 1'b1;
        end
    end

    assign standstill_flag = standstill_ff;

    ////////////////////////////////////////////////////////////////////////////
    // interrupts

    logic [IRQ_W-1:0] irq_status_ff;
    logic [IRQ_W-1:0] irq_mask_ff;
    logic [IRQ_W-1:0] irq_event;
    logic [IRQ_W-1:0] irq_clear;

    always_comb
    begin
        irq_event = '0;
        irq_event[IRQ_STANDSTILL_BIT] = ~active_edge && (idle_cnt_ff == CNT_W'(STANDSTILL_LIMIT - 1));
        irq_event[IRQ_RESUME_BIT] = active_edge & standstill_ff;
    end

    assign irq_clear = (reg_wr && reg_hit(reg_addr, OFS_IRQ_STATUS)) ? reg_wdata[IRQ_W-1:0] : '0;

    // a new event beats a simultaneous clear
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            irq_status_ff <= '0;
        end
        else
        begin
            irq_status_ff <= (irq_status_ff & ~irq_clear) | irq_event;
        end
    end

    assign irq = |(irq_status_ff & irq_mask_ff);

    ////////////////////////////////////////////////////////////////////////////
    // register port

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ctrl_ff <= '{dual_edge_select: RST_DUAL_EDGE_SELECT, resolution_select: RST_RES};
            irq_mask_ff <= RST_IRQ_MASK;
        end
        else if (reg_wr)
        begin
            if (reg_hit(reg_addr, OFS_CTRL))
            begin
                ctrl_ff.dual_edge_select <= reg_wdata[CTRL_DUAL_EDGE_SELECT_BIT];
                ctrl_ff.resolution_select <= reg_wdata[CTRL_RES_LSB +: RES_W];
            end
            if (reg_hit(reg_addr, OFS_IRQ_MASK))
            begin
                irq_mask_ff <= reg_wdata[IRQ_W-1:0];
            end
        end
    end

    logic [DATA_W-1:0] nxt_rdata;
    logic [DATA_W-1:0] rdata_ff;

    always_comb
    begin
        nxt_rdata = '0;
        case (reg_addr)
            OFS_CTRL:
            begin
                nxt_rdata[CTRL_DUAL_EDGE_SELECT_BIT] = ctrl_ff.dual_edge_select;
                nxt_rdata[CTRL_RES_LSB +: RES_W] = ctrl_ff.resolution_select;
            end
            OFS_POSITION: nxt_rdata[POS_W-1:0] = position_ff;
            OFS_CURRENT:
            begin
                nxt_rdata[CUR_A_MAG_LSB +: MAG_W] = mag_a;
                nxt_rdata[CUR_A_POL_BIT] = pol_a_ff;
                nxt_rdata[CUR_B_MAG_LSB +: MAG_W] = mag_b;
                nxt_rdata[CUR_B_POL_BIT] = pol_b_ff;
            end
            OFS_STATUS:
            begin
                nxt_rdata[STAT_STANDSTILL_BIT] = standstill_ff;
                nxt_rdata[STAT_DIR_BIT] = dir_sync;
                nxt_rdata[STAT_STEP_BIT] = step_sync;
            end
            OFS_IRQ_STATUS: nxt_rdata[IRQ_W-1:0] = irq_status_ff;
            OFS_IRQ_MASK: nxt_rdata[IRQ_W-1:0] = irq_mask_ff;
            default: nxt_rdata = '0;
        endcase
    end

    // read data valid only in the cycle after the strobe
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rdata_ff <= '0;
        end
        else
        begin
            rdata_ff <= reg_rd ? nxt_rdata : '0;
        end
    end

    assign reg_rdata = rdata_ff;

endmodule

// [bench/sdi_ctl_model.sv]
// motion controller model driving the step and direction pins
`timescale 1ns/10ps
module sdi_ctl_model (
    input wire logic clk,
    input wire logic go,
    input wire logic dir_req,
    input wire logic dual,
    input wire logic [3:0] gap,
    output logic step_pin,
    output logic dir_pin,
    output logic busy
);
    initial
    begin
        step_pin = 1'h0;
        dir_pin = 1'h0;
        busy = 1'h0;
    end
    // pin changes at least two clocks apart, one toggle per step in dual mode
    always @(posedge clk)
    begin
        if (go && !busy)
        begin
            busy <= 1'h1;
            dir_pin <= dir_req;
            // direction settles well before the step edge and holds after it
            repeat (2) @(posedge clk);
            step_pin <= dual ? ~step_pin : 1'h1;
            repeat (gap + 2) @(posedge clk);
            if (!dual)
            begin
                step_pin <= 1'h0;
                repeat (gap + 2) @(posedge clk);
            end
            busy <= 1'h0;
        end
    end
endmodule

// [bench/sdi_indexer_properties.sv]
// port checker of the step/direction indexer
`timescale 1ns/10ps
module sdi_indexer_properties
    import sdi_pkg::*;
#(
    parameter int LIMIT = 64
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic step_pin,
    input wire logic dir_pin,
    input wire logic [sdi_pkg::POS_W-1:0] microstep_position,
    input wire sdi_pkg::sdi_coil_s coil_a,
    input wire sdi_pkg::sdi_coil_s coil_b,
    input wire logic coil_a_out_first,
    input wire logic coil_a_out_second,
    input wire logic coil_b_out_first,
    input wire logic coil_b_out_second,
    input wire logic standstill_flag
);
    logic [3:0] sh_ff;
    logic [3:0] dh_ff;
    logic [POS_W-1:0] pp_ff;
    logic rst_d_ff;
    int idle_ff;
    logic moved;
    logic [POS_W-1:0] up;
    logic [POS_W-1:0] dn;
    assign moved = microstep_position != pp_ff;
    assign up = microstep_position - pp_ff;
    assign dn = pp_ff - microstep_position;
    // pin history, previous position and idle count
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            sh_ff <= '0;
            dh_ff <= '0;
            pp_ff <= '0;
            rst_d_ff <= 1'h1;
            idle_ff <= 0;
        end
        else
        begin
            sh_ff <= {sh_ff[2:0], step_pin};
            dh_ff <= {dh_ff[2:0], dir_pin};
            pp_ff <= microstep_position;
            rst_d_ff <= 1'h0;
            idle_ff <= moved ? 0 : ((idle_ff < LIMIT + 8) ? idle_ff + 1 : idle_ff);
        end
    end
    ////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    a_step_cause: assert property (moved |-> (sh_ff[2] != sh_ff[3]) || (sh_ff[1] != sh_ff[2]))
        else $error("position moved without a synced step change");
    a_step_size: assert property (moved |-> $onehot(up) || $onehot(dn))
        else $error("position moved by other than a power of two");
    a_step_sign: assert property (moved && (dh_ff[1] == dh_ff[3]) |-> $onehot(dh_ff[2] ? dn : up))
        else $error("position moved against the direction pin");
    a_coil_pol: assert property (!rst_d_ff |-> coil_a.polarity == pp_ff[9] &&
        coil_b.polarity == ^pp_ff[9:8])
        else $error("coil polarity does not follow the position");
    a_pol_pins: assert property (coil_a_out_second == coil_a.polarity &&
        coil_a_out_first == !coil_a.polarity)
        else $error("coil A output pins disagree with polarity");
    a_pol_pins_b: assert property (coil_b_out_second == coil_b.polarity &&
        coil_b_out_first == !coil_b.polarity)
        else $error("coil B output pins disagree with polarity");
    a_mag_range: assert property (!rst_d_ff |-> coil_a.magnitude inside {[8'h01:8'hF8]})
        else $error("coil A magnitude outside the table range");
    a_half_mag: assert property (!rst_d_ff && pp_ff[7:0] == 8'h00 |->
        {coil_a.magnitude, coil_b.magnitude} == (pp_ff[8] ? 16'hF801 : 16'h01F8))
        else $error("half step magnitudes wrong");
    a_full_mag: assert property (!rst_d_ff && pp_ff[7:0] == 8'h80 |->
        {coil_a.magnitude, coil_b.magnitude} == (pp_ff[8] ? 16'hAFB0 : 16'hB0AF))
        else $error("full step magnitudes wrong");
    a_still_clear: assert property (moved |-> !standstill_flag)
        else $error("standstill flag stayed up across a step");
    a_still_late: assert property (idle_ff == LIMIT + 4 |-> standstill_flag)
        else $error("standstill flag missing after the idle limit");
    a_still_early: assert property ($rose(standstill_flag) |-> idle_ff >= LIMIT - 3)
        else $error("standstill flag came too early");
    cover property ($rose(standstill_flag));
    cover property (moved && dh_ff[2]);
    cover property (microstep_position == 10'h380);
endmodule

bind sdi_indexer sdi_indexer_properties #(.LIMIT(STANDSTILL_LIMIT)) i_props (
    .clk(clk), .sys_rst(sys_rst), .step_pin(step_pin), .dir_pin(dir_pin),
    .microstep_position(microstep_position), .coil_a(coil_a), .coil_b(coil_b),
    .coil_a_out_first(coil_a_out_first), .coil_a_out_second(coil_a_out_second),
    .coil_b_out_first(coil_b_out_first), .coil_b_out_second(coil_b_out_second),
    .standstill_flag(standstill_flag)
);

// [bench/tb.sv]
// self-checking bench of the step/direction indexer
`timescale 1ns/10ps
module tb;
    import sdi_pkg::*;
    localparam int LIM = 64;
    logic clk = 1'h0;
    logic sys_rst = 1'h1;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wdata = '0;
    logic reg_wr = 1'h0;
    logic reg_rd = 1'h0;
    logic go = 1'h0;
    logic dreq = 1'h0;
    logic dual = 1'h0;
    logic [3:0] gap = 4'h0;
    logic step_pin;
    logic dir_pin;
    logic busy;
    logic [DATA_W-1:0] reg_rdata;
    logic irq;
    logic rd_d = 1'h0;
    logic lastd = 1'h0;
    logic [DATA_W-1:0] expq[$];
    logic [POS_W-1:0] ep = '0;
    logic [31:0] rnd = 32'h0000_79A3;
    int num_errors = 0;
    int checked = 0;
    int res = 0;
    always #4 clk = ~clk;
    sdi_indexer #(.STANDSTILL_LIMIT(LIM)) i_dut (
        .clk(clk), .sys_rst(sys_rst), .step_pin(step_pin), .dir_pin(dir_pin), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
        .microstep_position(), .coil_a(), .coil_b(), .coil_a_out_first(), .coil_a_out_second(),
        .coil_b_out_first(), .coil_b_out_second(), .standstill_flag()
    );
    sdi_ctl_model i_ctl (
        .clk(clk), .go(go), .dir_req(dreq), .dual(dual), .gap(gap),
        .step_pin(step_pin), .dir_pin(dir_pin), .busy(busy)
    );
    ////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    function automatic logic [POS_W-1:0] sz(int r);
        return (r > 8) ? 10'h100 : POS_W'(1 << r);
    endfunction
    // only the table entries that multiples of 128 reach
    function automatic logic [8:0] coil(logic [POS_W-1:0] p);
        logic [7:0] i;
        i = p[8] ? ~p[7:0] : p[7:0];
        case (i)
            8'h00: return {p[9], 8'h01};
            8'h7F: return {p[9], 8'hAF};
            8'h80: return {p[9], 8'hB0};
            default: return {p[9], 8'hF8};
        endcase
    endfunction
    function automatic logic [31:0] cur(logic [POS_W-1:0] p);
        return {7'h00, coil(p + QUARTER_WAVE), 7'h00, coil(p)};
    endfunction
    task automatic chk(logic [31:0] g, logic [31:0] e);
        checked++;
        if (g !== e)
        begin
            num_errors++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    // one bus cycle; for a read, d is the expected data
    task automatic op(logic w, logic r, logic [7:0] a, logic [31:0] d);
        reg_wr <= w;
        reg_rd <= r;
        reg_addr <= a;
        reg_wdata <= d;
        if (r)
            expq.push_back(d);
        @(posedge clk);
    endtask
    task automatic setc(int r, logic e);
        res = r;
        dual <= e;
        op(1'h1, 1'h0, OFS_CTRL, (32'(r) << CTRL_RES_LSB) | (32'(e) << CTRL_DUAL_EDGE_SELECT_BIT));
    endtask
    task automatic step(logic d);
        int n;
        dreq <= d;
        go <= 1'h1;
        op(1'h0, 1'h0, 8'h00, 32'h0);
        go <= 1'h0;
        @(posedge clk);
        for (n = 0; n < 60 && busy === 1'h1; n++)
            @(posedge clk);
        // sync, position and coil stages settle
        repeat (4) @(posedge clk);
        ep = d ? ep - sz(res) : ep + sz(res);
        lastd = d;
    endtask
    task automatic wrap_up();
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge clk)
    begin
        if (rd_d && expq.size() > 0)
            chk(reg_rdata, expq.pop_front());
        rd_d <= reg_rd;
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        num_errors++;
        wrap_up();
    end
    initial
    begin
        repeat (16) @(posedge clk);
        sys_rst <= 1'h0;
        @(posedge clk);
        op(1'h0, 1'h1, OFS_CTRL, 32'h0);
        op(1'h0, 1'h1, OFS_CURRENT, cur(10'h000));
        op(1'h0, 1'h1, OFS_IRQ_MASK, 32'h0);
        op(1'h0, 1'h1, 8'h18, 32'h0);
        op(1'h1, 1'h0, OFS_POSITION, 32'h3FF);
        op(1'h0, 1'h1, OFS_POSITION, 32'h0);
        for (int i = 0; i < 13; i++)
        begin
            // coarse steps start from matching positions, except the last full step, taken from 128
            setc((i < 5 || i == 12) ? 8 : 7, 1'h0);
            step(i >= 8);
            op(1'h0, 1'h1, OFS_POSITION, 32'(ep));
            op(1'h0, 1'h1, OFS_CURRENT, cur(ep));
        end
        setc(0, 1'h1);
        step(1'h0);
        step(1'h0);
        op(1'h0, 1'h1, OFS_POSITION, 32'(ep));
        setc(0, 1'h0);
        step(1'h1);
        op(1'h0, 1'h1, OFS_POSITION, 32'(ep));
        for (int r = 0; r < 16; r++)
        begin
            rnd = xs(rnd);
            gap <= {2'h0, rnd[1:0]};
            setc(r, 1'h0);
            step(rnd[4]);
            op(1'h0, 1'h1, OFS_POSITION, 32'(ep));
        end
        op(1'h1, 1'h0, OFS_IRQ_STATUS, 32'h3);
        op(1'h0, 1'h0, 8'h00, 32'h0);
        repeat (LIM + 8) @(posedge clk);
        op(1'h0, 1'h1, OFS_STATUS, {30'h0, lastd, 1'h1});
        op(1'h0, 1'h1, OFS_IRQ_STATUS, 32'h1);
        op(1'h0, 1'h0, 8'h00, 32'h0);
        chk(32'(irq), 32'h0);
        op(1'h1, 1'h0, OFS_IRQ_MASK, 32'h1);
        op(1'h0, 1'h0, 8'h00, 32'h0);
        chk(32'(irq), 32'h1);
        op(1'h1, 1'h0, OFS_IRQ_STATUS, 32'h1);
        op(1'h0, 1'h0, 8'h00, 32'h0);
        chk(32'(irq), 32'h0);
        step(1'h0);
        op(1'h0, 1'h1, OFS_IRQ_STATUS, 32'h2);
        op(1'h0, 1'h1, OFS_STATUS, 32'h0);
        op(1'h1, 1'h0, OFS_IRQ_MASK, 32'h2);
        op(1'h0, 1'h0, 8'h00, 32'h0);
        chk(32'(irq), 32'h1);
        op(1'h1, 1'h0, OFS_IRQ_STATUS, 32'h2);
        op(1'h0, 1'h0, 8'h00, 32'h0);
        chk(32'(irq), 32'h0);
        repeat (2) @(posedge clk);
        wrap_up();
    end
endmodule
